// >>> fpec_pkg.sv
`default_nettype none
package fpec_pkg;
    // byte addresses of the two control registers on the cpu bus
    localparam logic [15:0] FPEC_ADDR_ONE = 16'hff80;
    localparam logic [15:0] FPEC_ADDR_TWO = 16'hff81;
    // field positions in flash_mode_control_one
    localparam int FPEC_HW_ALLOW_BIT = 7;
    localparam int FPEC_SW_ALLOW_BIT = 6;
    localparam int FPEC_BLANK_CHECK_BIT = 3;
    localparam int FPEC_WRITE_CHECK_BIT = 2;
    localparam int FPEC_ERASE_GO_BIT = 1;
    localparam int FPEC_PROGRAM_GO_BIT = 0;
    // field positions in flash_mode_control_two
    localparam int FPEC_OP_FAULT_BIT = 7;
    localparam int FPEC_BLANK_ARM_BIT = 1;
    localparam int FPEC_BURN_ARM_BIT = 0;
    // reset value of the held write data and of the read data
    localparam logic [7:0] FPEC_RESET_BYTE = 8'h00;
    // a bus transfer takes two states
    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_second = 2'b10
    } fpec_state_type;
endpackage : fpec_pkg
`default_nettype wire

// >>> fpec_sync.sv
`default_nettype none
// two-flop synchroniser for a level that arrives from a pin
module fpec_sync
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic pin_in,
    output logic level_out
);
    logic meta_reg; // first stage, read only by the second
    logic meta_next;
    logic level_reg; // second stage, safe to use
    logic level_next;

    // next values: plain shift
    always_comb
    begin
        meta_next = pin_in;
        level_next = meta_reg;
    end

    // registers; a reset reads the pin as low until it has passed both stages
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            meta_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= meta_next;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule : fpec_sync
`default_nettype wire

// >>> fpec_core.sv
// How it works
// R1: bit 7 mirrors the hardware allow pin
// R2: register one reinitialised on reset and standby
// R3: sw allow writable only with hw allow
// R4: check bits writable only with both allows
// R5: erase go needs both allows and blank arm
// R6: program go needs both allows and burn arm
// R7: software: allow, then burn arm, then go
// R8: software: allow, then blank arm, then go
// R9: check modes follow their check bits
// R10: bits 5 and 4 read zero
// R11: register two resets zero, bits 6-2 zero
// R12: arm bits cleared in standby and protect
// R13: fault flag sticky, cleared only by reset
// R14: arm bits settable only with both allows
// R15: software: one mode bit per write
// R16: software: set sw allow before others
// R17: software: arm watchdog before go bits
// R18: program go written 1 enters, 0 leaves; a 0 is refused while burn arm is clear
// R19: deselected registers ignore bus, keep contents
// R20: byte access only, two bus states
// R21: refused bit keeps value, others still gated
`default_nettype none
module fpec_core
    import fpec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hw_write_allow_pin,
    input wire logic ctrl_reg_select,
    input wire logic standby,
    input wire logic op_fail,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic bus_byte,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic bus_ack,
    output logic [7:0] bus_rdata,
    output logic program_mode,
    output logic erase_mode,
    output logic write_check_mode,
    output logic blank_check_mode,
    output logic error_protect
);
    logic hw_sync; // hardware allow after two flops
    fpec_state_type state_reg, state_next; // bus transfer phase
    logic [15:0] addr_reg, addr_next; // address held for the second state
    logic [7:0] wdata_reg, wdata_next; // write data held likewise
    logic write_reg, write_next;
    logic byte_reg, byte_next;
    logic sw_reg, sw_next; // sw_write_allow
    logic bcheck_reg, bcheck_next; // blank_check
    logic wcheck_reg, wcheck_next; // write_check
    logic ego_reg, ego_next; // erase go
    logic pgo_reg, pgo_next; // program go
    logic barm_reg, barm_next; // blank_arm
    logic parm_reg, parm_next; // burn_arm
    logic fault_reg, fault_next; // op_fault
    logic [7:0] rdata_reg, rdata_next;
    logic hit; // valid access in its second state
    logic wr_one;
    logic wr_two;
    logic allow_both;
    logic [7:0] one_view;
    logic [7:0] two_view;
    // assertions run on sys_clk and rest while reset is held
    default clocking cb_sys @(posedge sys_clk); endclocking
    default disable iff (srst);

    // the pin is asynchronous to sys_clk
    fpec_sync u_fpec_sync
    (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin_in(hw_write_allow_pin),
        .level_out(hw_sync)
    );

    // decode in the second state; wrong widths or deselection do nothing
    always_comb
    begin
        hit = (state_reg == st_second) && byte_reg && ctrl_reg_select; // R19 R20
        wr_one = hit && write_reg && (addr_reg == FPEC_ADDR_ONE);
        wr_two = hit && write_reg && (addr_reg == FPEC_ADDR_TWO);
        allow_both = hw_sync && sw_reg;
        one_view = {hw_sync, sw_reg, 2'b00, bcheck_reg, wcheck_reg, ego_reg, pgo_reg}; // R1 R10
        two_view = {fault_reg, 5'b00000, barm_reg, parm_reg}; // R11
    end

    // bus phase: a request is taken in idle, answered in the second state
    always_comb
    begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        write_next = write_reg;
        byte_next = byte_reg;
        rdata_next = rdata_reg;
        case (state_reg)
            st_idle:
            begin
                if (bus_req)
                begin
                    state_next = st_second; // R20
                    addr_next = bus_addr;
                    wdata_next = bus_wdata;
                    write_next = bus_write;
                    byte_next = bus_byte;
                end
            end
            st_second:
            begin
                state_next = st_idle;
                // deselected or unmapped reads return zero
                rdata_next = FPEC_RESET_BYTE; // R19
                if (hit && !write_reg && addr_reg == FPEC_ADDR_ONE)
                begin
                    rdata_next = one_view;
                end
                else if (hit && !write_reg && addr_reg == FPEC_ADDR_TWO)
                begin
                    rdata_next = two_view;
                end
            end
            default:
            begin
                state_next = st_idle;
            end
        endcase
    end

    // control bits: gated writes, then forced clears, which take priority
    always_comb
    begin
        sw_next = sw_reg;
        bcheck_next = bcheck_reg;
        wcheck_next = wcheck_reg;
        ego_next = ego_reg;
        pgo_next = pgo_reg;
        barm_next = barm_reg;
        parm_next = parm_reg;
        // a failure report is sticky; nothing but reset clears it
        fault_next = fault_reg || op_fail; // R13
        if (wr_one)
        begin
            // each bit checks its own condition; a refused one holds
            if (hw_sync)
            begin
                sw_next = wdata_reg[FPEC_SW_ALLOW_BIT]; // R3 R21
            end
            if (allow_both)
            begin
                bcheck_next = wdata_reg[FPEC_BLANK_CHECK_BIT]; // R4 R9
                wcheck_next = wdata_reg[FPEC_WRITE_CHECK_BIT]; // R4 R9
            end
            if (allow_both && barm_reg)
            begin
                ego_next = wdata_reg[FPEC_ERASE_GO_BIT]; // R5
            end
            if (allow_both && parm_reg)
            begin
                pgo_next = wdata_reg[FPEC_PROGRAM_GO_BIT]; // R6 R18
            end
        end
        if (wr_two && allow_both)
        begin
            barm_next = wdata_reg[FPEC_BLANK_ARM_BIT]; // R14
            parm_next = wdata_reg[FPEC_BURN_ARM_BIT]; // R14
        end
        // software protect: without sw allow nothing can stay armed
        if (!sw_reg)
        begin
            barm_next = 1'b0; // R12
            parm_next = 1'b0;
            ego_next = 1'b0;
            pgo_next = 1'b0;
        end
        // error protect stops program and erase in flight; the check bits keep their values
        if (fault_reg)
        begin
            ego_next = 1'b0; // R13
            pgo_next = 1'b0;
        end
        // standby reinitialises, hardware protect drops all enables
        if (standby || !hw_sync)
        begin
            sw_next = 1'b0; // R2 R12
            bcheck_next = 1'b0;
            wcheck_next = 1'b0;
            ego_next = 1'b0;
            pgo_next = 1'b0;
            barm_next = 1'b0;
            parm_next = 1'b0;
        end
    end

    // registers only
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= st_idle;
            addr_reg <= 16'h0000;
            wdata_reg <= FPEC_RESET_BYTE;
            write_reg <= 1'b0;
            byte_reg <= 1'b0;
            sw_reg <= 1'b0; // R2
            bcheck_reg <= 1'b0;
            wcheck_reg <= 1'b0;
            ego_reg <= 1'b0;
            pgo_reg <= 1'b0; // R18
            barm_reg <= 1'b0; // R11
            parm_reg <= 1'b0;
            fault_reg <= 1'b0; // R13
            rdata_reg <= FPEC_RESET_BYTE;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            write_reg <= write_next;
            byte_reg <= byte_next;
            sw_reg <= sw_next;
            bcheck_reg <= bcheck_next;
            wcheck_reg <= wcheck_next;
            ego_reg <= ego_next;
            pgo_reg <= pgo_next;
            barm_reg <= barm_next;
            parm_reg <= parm_next;
            fault_reg <= fault_next;
            rdata_reg <= rdata_next;
        end
    end

    // ack is combinational from the phase; data and modes from flops
    assign bus_ack = (state_reg == st_second);
    assign bus_rdata = rdata_reg;
    assign program_mode = pgo_reg; // R18
    assign erase_mode = ego_reg;
    assign write_check_mode = wcheck_reg; // R9
    assign blank_check_mode = bcheck_reg; // R9
    assign error_protect = fault_reg; // R13

    property p_mirror;
        (hit && !write_reg && addr_reg == FPEC_ADDR_ONE) |=> (bus_rdata[7] == $past(hw_sync));
    endproperty
    a_mirror: assert property (p_mirror) else $error("bit 7 not mirroring pin"); // R1
    property p_one_zero;
        (hit && !write_reg && addr_reg == FPEC_ADDR_ONE) |=> (bus_rdata[5:4] == 2'b00);
    endproperty
    a_one_zero: assert property (p_one_zero) else $error("reserved bits nonzero"); // R10
    property p_two_zero;
        (hit && !write_reg && addr_reg == FPEC_ADDR_TWO) |=> (bus_rdata[6:2] == 5'b00000);
    endproperty
    a_two_zero: assert property (p_two_zero) else $error("reserved bits nonzero"); // R11
    property p_sw_gate;
        $rose(sw_reg) |-> $past(hw_sync && wr_one);
    endproperty
    a_sw_gate: assert property (p_sw_gate) else $error("sw allow set without hw"); // R3
    property p_check_gate;
        ($rose(bcheck_reg) || $rose(wcheck_reg)) |-> $past(allow_both && wr_one);
    endproperty
    a_check_gate: assert property (p_check_gate) else $error("check bit set ungated"); // R4
    property p_ego_gate;
        $rose(ego_reg) |-> $past(allow_both && barm_reg && wr_one);
    endproperty
    a_ego_gate: assert property (p_ego_gate) else $error("erase go set ungated"); // R5
    property p_pgo_gate;
        $rose(pgo_reg) |-> $past(allow_both && parm_reg && wr_one);
    endproperty
    a_pgo_gate: assert property (p_pgo_gate) else $error("program go set ungated"); // R6
    property p_arm_clear;
        (standby || !hw_sync || !sw_reg) |=> (!barm_reg && !parm_reg);
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm bit survived protect"); // R12
    property p_fault_sticky;
        fault_reg |=> fault_reg;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag cleared"); // R13
    property p_two_states;
        (state_reg == st_idle && bus_req) |=> bus_ack ##1 !bus_ack;
    endproperty
    a_two_states: assert property (p_two_states) else $error("transfer not two states"); // R20
    property p_deselect;
        (bus_ack && !ctrl_reg_select) |=> (bus_rdata == FPEC_RESET_BYTE);
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselected read nonzero"); // R19

    c_program: cover property ($rose(pgo_reg));
    c_erase: cover property ($rose(ego_reg));
    c_fault: cover property ($rose(fault_reg));
    c_verify: cover property ($rose(wcheck_reg));
endmodule : fpec_core
`default_nettype wire

// >>> test_flash_program_erase_control.sv
`default_nettype none
module test_flash_program_erase_control
    import fpec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // stimulus, all driven at the falling edge
    logic sys_clk = 1'b0, srst = 1'b1, pin = 1'b1, sel = 1'b1, sb = 1'b0, fail = 1'b0;
    logic req = 1'b0, wr = 1'b0, byt = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    // design outputs and last read byte
    logic ack, pm, em, wcm, bcm, ep;
    logic [7:0] rdata, got;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // reference model, one bit per stored flag
    bit hw, sw, bc, wc, eg, pg, ba, pa, flt;
    localparam logic [15:0] A1 = FPEC_ADDR_ONE;
    localparam logic [15:0] A2 = FPEC_ADDR_TWO;

    fpec_core u_fpec_core (.sys_clk(sys_clk), .srst(srst), .hw_write_allow_pin(pin),
        .ctrl_reg_select(sel), .standby(sb), .op_fail(fail), .bus_req(req), .bus_write(wr),
        .bus_byte(byt), .bus_addr(addr), .bus_wdata(wdata), .bus_ack(ack), .bus_rdata(rdata),
        .program_mode(pm), .erase_mode(em), .write_check_mode(wcm), .blank_check_mode(bcm),
        .error_protect(ep));

    // free-running 100 MHz clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            $display("Error at %0t: cycles %h limit %h", $time, cycles, 20000);
            end_of_test();
        end
    end

    // forced clears; standby and pin low first, since they also drop sw
    function automatic void settle();
        if (sb || !hw) {sw, bc, wc, eg, pg, ba, pa} = '0;
        if (!sw) {ba, pa, eg, pg} = '0;
        if (flt) {eg, pg} = '0;
    endfunction : settle

    // expected read byte; deselect, bad width and holes read zero
    function automatic logic [7:0] model_rd(input logic [15:0] a);
        if (!sel || !byt) return 8'h00;
        if (a == A1) return {hw, sw, 2'b00, bc, wc, eg, pg};
        if (a == A2) return {flt, 5'h00, ba, pa};
        return 8'h00;
    endfunction : model_rd

    // gating is judged on the values held before the write
    function automatic void model_wr(input logic [15:0] a, input logic [7:0] d);
        bit old_sw;
        old_sw = sw;
        if (!sel || !byt) return;
        if (a == A1 && hw) sw = d[6];
        if (a == A1 && hw && old_sw)
        begin
            bc = d[3];
            wc = d[2];
            if (ba) eg = d[1];
            if (pa) pg = d[0];
        end
        if (a == A2 && hw && sw) {ba, pa} = d[1:0];
        settle();
    endfunction : model_wr

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_byte

    task automatic cmp_modes(input logic [4:0] g, input logic [4:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error at %0t: modes %h expected %h", $time, g, e);
        end
    endtask : cmp_modes

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // request held until the acknowledge is seen, then one spare cycle for clears
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        int k;
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        k = 0;
        do
        begin
            @(negedge sys_clk);
            k++;
        end
        while (ack !== 1'b1 && k < 8);
        if (ack !== 1'b1)
        begin
            num_errors++;
            $display("Error at %0t: ack %h expected %h", $time, ack, 1'b1);
        end
        // hold the request through the edge that samples ack high
        @(negedge sys_clk);
        got = rdata;
        req = 1'b0;
        @(negedge sys_clk);
    endtask : bus

    task automatic do_wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        model_wr(a, d);
        cmp_modes({pm, em, wcm, bcm, ep}, {pg, eg, wc, bc, flt});
    endtask : do_wr

    task automatic do_rd(input logic [15:0] a);
        bus(1'b0, a, 8'h00);
        cmp_byte(got, model_rd(a));
    endtask : do_rd

    // the pin passes a two-flop synchroniser, so allow four cycles
    task automatic set_pin(input logic v);
        pin = v;
        tick(4);
        hw = v;
        settle();
    endtask : set_pin

    task automatic do_reset();
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        {sw, bc, wc, eg, pg, ba, pa, flt} = '0;
        hw = pin;
        tick(4);
    endtask : do_reset

    task automatic end_of_test();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // main sequence
    initial
    begin
        logic [15:0] ra;
        logic [7:0] rd_byte;
        void'($urandom(59804));
        do_reset();
        do_rd(A1);
        do_rd(A2);
        set_pin(1'b0);
        do_wr(A1, 8'h40);
        do_rd(A1);
        set_pin(1'b1);
        $display("test reset and pin done");
        // setting order, gos refused while sw was still off
        do_wr(A2, 8'h03);
        do_wr(A1, 8'h43);
        do_wr(A1, 8'h7c);
        do_rd(A1);
        do_wr(A1, 8'h40);
        do_wr(A2, 8'hfd);
        do_rd(A2);
        do_wr(A1, 8'h41);
        do_wr(A1, 8'h42);
        do_wr(A2, 8'h02);
        do_wr(A1, 8'h42);
        do_rd(A1);
        $display("test gating done");
        // deselect, wrong width and a hole in the map
        sel = 1'b0;
        do_wr(A1, 8'h00);
        do_rd(A1);
        sel = 1'b1;
        byt = 1'b0;
        do_wr(A2, 8'h00);
        do_rd(A2);
        byt = 1'b1;
        do_rd(16'hff82);
        do_rd(A1);
        $display("test access done");
        // standby, software protect and hardware protect
        sb = 1'b1;
        tick(2);
        settle();
        sb = 1'b0;
        do_rd(A1);
        do_rd(A2);
        do_wr(A1, 8'h40);
        do_wr(A2, 8'h01);
        do_wr(A1, 8'h00);
        do_rd(A2);
        do_wr(A1, 8'h40);
        do_wr(A2, 8'h02);
        set_pin(1'b0);
        do_rd(A2);
        set_pin(1'b1);
        $display("test protect done");
        // random traffic on both registers
        repeat (60)
        begin
            ra = ($urandom_range(1) == 0) ? A1 : A2;
            rd_byte = 8'($urandom);
            if ($urandom_range(1) == 0)
                do_wr(ra, rd_byte);
            else
                do_rd(ra);
        end
        $display("test random done");
        // failure report forces error protect until reset
        do_reset();
        do_wr(A1, 8'h40);
        do_wr(A2, 8'h01);
        do_wr(A1, 8'h41);
        fail = 1'b1;
        tick(1);
        fail = 1'b0;
        tick(2);
        flt = 1'b1;
        settle();
        do_wr(A2, 8'h80);
        do_rd(A2);
        pin = 1'b0;
        do_reset();
        do_rd(A2);
        do_rd(A1);
        $display("test fault done");
        end_of_test();
    end
endmodule : test_flash_program_erase_control
`default_nettype wire
